// [rtl/nvt_time_core.sv]
// timekeeping counters with double-buffered user registers
`timescale 1ns/100ps
module nvt_time_core
   import nvt_pkg::*;
#(
   parameter int unsigned SEC_DIV  = SEC_CYCLES,
   parameter int unsigned TEST_DIV = TEST_CYCLES
) (
   input wire logic      clk_sys,
   input wire logic      rst_n,
   nvt_time_if.core      bus
);
   // =============================================
   // bcd helpers
   function automatic logic [7:0] bcdInc(input logic [7:0] v);
      if (v[3:0] == 4'h9) bcdInc = {v[7:4] + 4'h1, 4'h0};
      else bcdInc = {v[7:4], v[3:0] + 4'h1};
   endfunction : bcdInc

   function automatic logic [7:0] monthLen(input logic [7:0] m, input logic [7:0] y);
      logic leap;
      // bcd year divisible by four: tens even and units 0,4,8, or tens odd and units 2,6
      leap = (y[4] == 1'b0) ? (y[1:0] == 2'b00 && !y[3] || y[3:0] == 4'h8)
                            : (y[3:0] == 4'h2 || y[3:0] == 4'h6);
      unique case (m)
         8'h04, 8'h06, 8'h09, 8'h11: monthLen = 8'h30;
         BCD_02:                     monthLen = leap ? 8'h29 : 8'h28;
         default:                    monthLen = 8'h31;
      endcase
   endfunction : monthLen

   // =============================================
   // control and user copy
   nvt_time_t cnt_q, user_q;
   logic      set_q, freeze_q, setDone_q;
   logic      halt;
   logic [31:0] secDiv_q, testDiv_q;
   logic      secTick, square_q;
   logic [7:0] userByte [0:7];
   logic [7:0] secNext;

   // a function result cannot be part-selected, so the increment gets a net of its own
   assign secNext = bcdInc(cnt_q.sec);

   assign halt = user_q.sec[CRYSTAL_HALT_BIT];

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         set_q    <= 1'b0;
         freeze_q <= 1'b0;
      end else if (bus.writeStb && bus.regSel == 3'd0) begin
         set_q    <= bus.wrData[CTRL_SET_BIT];
         freeze_q <= bus.wrData[CTRL_FREEZE_BIT];
      end
   end

   // =============================================
   // one second divider; stops with the crystal
   always_ff @(posedge clk_sys) begin
      if (!rst_n || halt) secDiv_q <= '0;
      else if (secDiv_q == SEC_DIV - 1) secDiv_q <= '0;
      else secDiv_q <= secDiv_q + 32'd1;
   end
   assign secTick = !halt && (secDiv_q == SEC_DIV - 1);

   always_ff @(posedge clk_sys) begin
      if (!rst_n || halt) begin
         testDiv_q <= '0;
         square_q  <= 1'b0;
      end else if (testDiv_q == TEST_DIV - 1) begin
         testDiv_q <= '0;
         square_q  <= ~square_q;
      end else begin
         testDiv_q <= testDiv_q + 32'd1;
      end
   end

   // =============================================
   // running counters
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         cnt_q     <= TIME_RESET;
         setDone_q <= 1'b0;
      end else begin
         setDone_q <= set_q;
         if (setDone_q && !set_q) begin
            cnt_q <= user_q;
         end else if (secTick) begin
            cnt_q.sec[6:0] <= secNext[6:0];
            if (cnt_q.sec[6:0] == BCD_59[6:0]) begin
               cnt_q.sec[6:0] <= 7'h00;
               cnt_q.min <= (cnt_q.min == BCD_59) ? 8'h00 : bcdInc(cnt_q.min);
               if (cnt_q.min == BCD_59) begin
                  cnt_q.hour <= (cnt_q.hour == BCD_23) ? 8'h00 : bcdInc(cnt_q.hour);
                  if (cnt_q.hour == BCD_23) begin
                     cnt_q.wday[2:0] <= (cnt_q.wday[2:0] == BCD_07[2:0]) ? 3'd1
                                        : cnt_q.wday[2:0] + 3'd1;
                     if (cnt_q.mday == monthLen(cnt_q.month, cnt_q.year)) begin
                        cnt_q.mday <= RST_MDAY;
                        cnt_q.month <= (cnt_q.month == BCD_12) ? RST_MONTH
                                       : bcdInc(cnt_q.month);
                        if (cnt_q.month == BCD_12)
                           cnt_q.year <= (cnt_q.year == BCD_99) ? 8'h00
                                         : bcdInc(cnt_q.year);
                     end else begin
                        cnt_q.mday <= bcdInc(cnt_q.mday);
                     end
                  end
               end
            end
         end
         // halt and test bits live in the user copy so software sees them at once
         cnt_q.sec[CRYSTAL_HALT_BIT]  <= 1'b0;
         cnt_q.wday[SQUARE_TEST_BIT]  <= 1'b0;
      end
   end

   // =============================================
   // user registers: follow the counters unless frozen or being set
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         user_q <= TIME_RESET;
      end else if (bus.writeStb && set_q) begin
         unique case (bus.regSel)
            3'd1: user_q.sec   <= bus.wrData & MASK_SEC;
            3'd2: user_q.min   <= bus.wrData & MASK_MIN;
            3'd3: user_q.hour  <= bus.wrData & MASK_HOUR;
            3'd4: user_q.wday  <= bus.wrData & MASK_WDAY;
            3'd5: user_q.mday  <= bus.wrData & MASK_MDAY;
            3'd6: user_q.month <= bus.wrData & MASK_MONTH;
            3'd7: user_q.year  <= bus.wrData & MASK_YEAR;
            3'd0: ;
         endcase
      end else if (bus.writeStb && bus.regSel == 3'd1) begin
         // stop bit may be written at any time
         user_q.sec[CRYSTAL_HALT_BIT] <= bus.wrData[CRYSTAL_HALT_BIT];
      end else if (bus.writeStb && bus.regSel == 3'd4) begin
         user_q.wday[SQUARE_TEST_BIT] <= bus.wrData[SQUARE_TEST_BIT];
      end else if (!freeze_q && !set_q && !setDone_q) begin
         // refresh all fields in one edge once freeze drops
         user_q.sec[6:0]  <= cnt_q.sec[6:0];
         user_q.min       <= cnt_q.min;
         user_q.hour      <= cnt_q.hour;
         user_q.wday[2:0] <= cnt_q.wday[2:0];
         user_q.mday      <= cnt_q.mday;
         user_q.month     <= cnt_q.month;
         user_q.year      <= cnt_q.year;
      end
      // frozen or set: user copy holds
   end

   always_comb begin
      userByte[0] = {set_q, freeze_q, 6'h00};
      userByte[1] = user_q.sec;
      // test square replaces the seconds lsb while enabled and the crystal is not halted
      if (user_q.wday[SQUARE_TEST_BIT] && !halt)
         userByte[1][0] = square_q;
      userByte[2] = user_q.min;
      userByte[3] = user_q.hour;
      userByte[4] = user_q.wday;
      userByte[5] = user_q.mday;
      userByte[6] = user_q.month;
      userByte[7] = user_q.year;
   end
   assign bus.rdData = userByte[bus.regSel];
endmodule : nvt_time_core

// [rtl/nvt_pkg.sv]
// constants and types shared by the timekeeping ram design
package nvt_pkg;
   localparam int unsigned ADDR_W        = 13;
   localparam int unsigned DATA_W        = 8;
   localparam int unsigned CLK_HZ        = 100_000_000;
   localparam int unsigned SEC_HZ        = 1;
   localparam int unsigned TEST_HZ       = 512;
   localparam int unsigned SEC_CYCLES    = CLK_HZ / SEC_HZ;
   // one toggle per half period of the test square
   localparam int unsigned TEST_CYCLES   = CLK_HZ / (TEST_HZ * 2);
   // =============================================
   // register map
   localparam logic [12:0] ADDR_CLOCK_CONTROL = 13'h1ff8;
   localparam logic [12:0] ADDR_SECONDS_COUNT = 13'h1ff9;
   localparam logic [12:0] ADDR_MINUTES_COUNT = 13'h1ffa;
   localparam logic [12:0] ADDR_HOURS_COUNT   = 13'h1ffb;
   localparam logic [12:0] ADDR_WEEKDAY_COUNT = 13'h1ffc;
   localparam logic [12:0] ADDR_DAY_OF_MONTH  = 13'h1ffd;
   localparam logic [12:0] ADDR_MONTH_COUNT   = 13'h1ffe;
   localparam logic [12:0] ADDR_YEAR_COUNT    = 13'h1fff;
   // =============================================
   // field positions
   localparam int unsigned CTRL_SET_BIT    = 7;
   localparam int unsigned CTRL_FREEZE_BIT = 6;
   localparam int unsigned CRYSTAL_HALT_BIT = 7;
   localparam int unsigned SQUARE_TEST_BIT  = 6;
   localparam logic [7:0] MASK_CTRL  = 8'hc0;
   localparam logic [7:0] MASK_SEC   = 8'hff;
   localparam logic [7:0] MASK_MIN   = 8'h7f;
   localparam logic [7:0] MASK_HOUR  = 8'h3f;
   localparam logic [7:0] MASK_WDAY  = 8'h47;
   localparam logic [7:0] MASK_MDAY  = 8'h3f;
   localparam logic [7:0] MASK_MONTH = 8'h1f;
   localparam logic [7:0] MASK_YEAR  = 8'hff;
   // =============================================
   // reset values and bcd constants of the time fields
   localparam logic [7:0] RST_SEC   = 8'h00;
   localparam logic [7:0] RST_MIN   = 8'h00;
   localparam logic [7:0] RST_HOUR  = 8'h00;
   localparam logic [7:0] RST_WDAY  = 8'h01;
   localparam logic [7:0] RST_MDAY  = 8'h01;
   localparam logic [7:0] RST_MONTH = 8'h01;
   localparam logic [7:0] RST_YEAR  = 8'h00;
   localparam logic [7:0] BCD_59    = 8'h59;
   localparam logic [7:0] BCD_23    = 8'h23;
   localparam logic [7:0] BCD_07    = 8'h07;
   localparam logic [7:0] BCD_12    = 8'h12;
   localparam logic [7:0] BCD_99    = 8'h99;
   localparam logic [7:0] BCD_02    = 8'h02;
   // =============================================
   typedef struct packed {
      logic [7:0] sec;
      logic [7:0] min;
      logic [7:0] hour;
      logic [7:0] wday;
      logic [7:0] mday;
      logic [7:0] month;
      logic [7:0] year;
   } nvt_time_t;
   localparam nvt_time_t TIME_RESET =
      '{RST_SEC, RST_MIN, RST_HOUR, RST_WDAY, RST_MDAY, RST_MONTH, RST_YEAR};
endpackage : nvt_pkg

// [rtl/nvt_time_if.sv]
// carrier between the bus front end and the timekeeping core
`timescale 1ns/100ps
interface nvt_time_if;
   import nvt_pkg::*;
   logic      writeStb;
   logic [2:0] regSel;
   logic [7:0] wrData;
   logic [7:0] rdData;
   modport core (input writeStb, input regSel, input wrData, output rdData);
   modport front (output writeStb, output regSel, output wrData, input rdData);
endinterface : nvt_time_if

// [rtl/nvt_timekeeper.sv]
// byte-wide sram with clock registers in the top eight locations
// =============================================
// Notes on behaviour
// - read-freeze bit at 1 stops copying counters to visible registers.
// - frozen registers show time captured at freeze; counters keep running.
// - clearing read-freeze refreshes all visible registers together within a second.
// - clock-set bit at 1 also halts visible register updates.
// - clearing clock-set copies visible registers into counters, counting resumes.
// - seconds msb at 1 stops the oscillator and timekeeping.
// - weekday bit 6 set makes seconds lsb toggle at 512Hz.
// - sustained seconds read shows data line zero toggling at 512Hz.
// - store strobe high with chip select active performs a read.
// - data driven only for select low, select hi high, output low, strobe high.
// - read data ripples through; address change gives indeterminate data briefly.
// - write occurs while strobe and select active; starts on the later one.
// - output low before strobe falls: read data, then release after strobe.
// - below power-fail threshold all access blocked by inhibiting chip select.
// - open-drain reset output held low during power fail.
// - below backup level clock runs and contents are preserved.
// - counters are bcd, 24-hour, with month length and leap years.
// - double-buffered registers; host access never disturbs counting.
`timescale 1ns/100ps
module nvt_timekeeper
   import nvt_pkg::*;
#(
   parameter int unsigned SEC_DIV  = SEC_CYCLES,
   parameter int unsigned TEST_DIV = TEST_CYCLES,
   parameter int unsigned AW       = ADDR_W
) (
   input  wire logic          clk_sys,
   input  wire logic          rst_n,
   input  wire logic [AW-1:0] addrIn,
   input  wire logic [7:0]    dataIn,
   output logic      [7:0]    dataOut,
   output logic               dataOe,
   input  wire logic          chipSelLow_n,
   input  wire logic          chip_select_hi,
   input  wire logic          outEnable_n,
   input  wire logic          storeStrobe_n,
   input  wire logic          powerFailIn,
   output logic               powerFailOut,
   output logic               powerFailOe
);
   // =============================================
   // three-stage pin synchronisers; change counts when stages two and three agree
   localparam int unsigned NPIN = AW + 8 + 5;
   logic [NPIN-1:0] pinRaw, s1_q, s2_q, s3_q, pin_q;
   // every stage resets to the deselected levels, so release cannot fake a select or a write
   localparam logic [NPIN-1:0] PIN_IDLE = {{(AW + 8){1'b0}}, 5'b10110};
   assign pinRaw = {addrIn, dataIn, chipSelLow_n, chip_select_hi, outEnable_n,
                    storeStrobe_n, powerFailIn};
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         s1_q  <= PIN_IDLE;
         s2_q  <= PIN_IDLE;
         s3_q  <= PIN_IDLE;
         pin_q <= PIN_IDLE;
      end else begin
         s1_q <= pinRaw;
         s2_q <= s1_q;
         s3_q <= s2_q;
         for (int i = 0; i < NPIN; i++)
            if (s2_q[i] == s3_q[i]) pin_q[i] <= s3_q[i];
      end
   end

   logic [AW-1:0] addr;
   logic [7:0]    wdata;
   logic          csLow_n, csHi, oe_n, we_n, pfail;
   assign {addr, wdata, csLow_n, csHi, oe_n, we_n, pfail} = pin_q;

   // =============================================
   // selection, inhibited during power fail
   logic selected, isClock, wrActive, wrActive_q, wrStart, rdActive;
   assign selected = !csLow_n && csHi && !pfail;
   assign isClock  = (addr[AW-1:3] == ADDR_CLOCK_CONTROL[AW-1:3]);
   assign wrActive = selected && !we_n;
   assign rdActive = selected && we_n;
   // start of write is the later of the two going active
   assign wrStart  = wrActive && !wrActive_q;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) wrActive_q <= 1'b0;
      else wrActive_q <= wrActive;
   end

   // =============================================
   // static ram array; clock locations shadow the top eight words
   localparam int unsigned DEPTH = 1 << AW;
   logic [7:0] mem [0:DEPTH-1];
   logic [7:0] memRd;
   // write on the end of the strobe so data set up late is still caught
   logic wrEnd;
   assign wrEnd = wrActive_q && !wrActive;
   logic [AW-1:0] wrAddr_q;
   logic [7:0]    wrData_q;
   always_ff @(posedge clk_sys) begin
      if (wrStart) wrAddr_q <= addr;
      if (wrActive) wrData_q <= wdata;
   end
   always_ff @(posedge clk_sys) begin
      if (wrEnd && !(wrAddr_q[AW-1:3] == ADDR_CLOCK_CONTROL[AW-1:3]))
         mem[wrAddr_q] <= wrData_q;
   end
   assign memRd = mem[addr];

   // =============================================
   // clock register block
   nvt_time_if tif ();
   assign tif.writeStb = wrEnd && (wrAddr_q[AW-1:3] == ADDR_CLOCK_CONTROL[AW-1:3]);
   assign tif.regSel   = wrEnd ? wrAddr_q[2:0] : addr[2:0];
   assign tif.wrData   = wrData_q;

   nvt_time_core #(
      .SEC_DIV  (SEC_DIV),
      .TEST_DIV (TEST_DIV)
   ) u_core (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .bus     (tif)
   );

   // =============================================
   // read data path; one cycle of old data after an address change
   logic [7:0] rdNow;
   assign rdNow = isClock ? tif.rdData : memRd;
   always_ff @(posedge clk_sys) begin
      if (!rst_n) dataOut <= 8'h00;
      else if (rdActive) dataOut <= rdNow;
   end

   // drive only in read mode; strobe falling releases the bus
   always_ff @(posedge clk_sys) begin
      if (!rst_n) dataOe <= 1'b0;
      else dataOe <= rdActive && !oe_n;
   end

   // =============================================
   // open-drain power-fail reset; pulls low while supply is out of range
   // counters keep their state through power fail
   assign powerFailOut = 1'b0;
   always_ff @(posedge clk_sys) begin
      if (!rst_n) powerFailOe <= 1'b0;
      else powerFailOe <= pfail;
   end
endmodule : nvt_timekeeper

// [tb/nvt_timekeeper_chk.sv]
// pin-level assertions for the timekeeping ram
`timescale 1ns/100ps
module nvt_timekeeper_chk
   import nvt_pkg::*;
#(
   parameter int unsigned AW = ADDR_W
) (
   input wire logic          clk_sys,
   input wire logic          rst_n,
   input wire logic [AW-1:0] addrIn,
   input wire logic [7:0]    dataIn,
   input wire logic [7:0]    dataOut,
   input wire logic          dataOe,
   input wire logic          chipSelLow_n,
   input wire logic          chip_select_hi,
   input wire logic          outEnable_n,
   input wire logic          storeStrobe_n,
   input wire logic          powerFailIn,
   input wire logic          powerFailOut,
   input wire logic          powerFailOe
);
   // =============================================
   // pin relations; input sync costs a few cycles, so windows are eight wide
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   wire logic rdOn;
   assign rdOn = !chipSelLow_n && chip_select_hi && !outEnable_n && storeStrobe_n && !powerFailIn;
   read_drive_a: assert property (rdOn [*8] |-> ##[0:4] dataOe)
      else $error("read held but data pins not driven");
   cs_low_off_a: assert property (chipSelLow_n [*8] |-> !dataOe)
      else $error("data driven while low select inactive");
   cs_hi_off_a: assert property (!chip_select_hi [*8] |-> !dataOe)
      else $error("data driven while high select inactive");
   oe_off_a: assert property (outEnable_n [*8] |-> !dataOe)
      else $error("data driven while output drive off");
   strobe_off_a: assert property ($fell(storeStrobe_n) ##1 !storeStrobe_n [*7] |-> !dataOe)
      else $error("data driven during store strobe");
   pf_block_a: assert property (powerFailIn [*8] |-> !dataOe)
      else $error("data driven during power fail");
   pf_hold_a: assert property ($rose(powerFailIn) ##1 powerFailIn [*7] |-> powerFailOe)
      else $error("reset pin not pulled during power fail");
   pf_clear_a: assert property (!powerFailIn [*8] |-> !powerFailOe)
      else $error("reset pin pulled with supply good");
   open_drain_a: assert property (powerFailOut == 1'b0)
      else $error("reset pin driven high");
endmodule : nvt_timekeeper_chk
bind nvt_timekeeper nvt_timekeeper_chk #(.AW(AW)) nvt_timekeeper_chk_inst (
   .clk_sys(clk_sys), .rst_n(rst_n), .addrIn(addrIn), .dataIn(dataIn), .dataOut(dataOut),
   .dataOe(dataOe), .chipSelLow_n(chipSelLow_n), .chip_select_hi(chip_select_hi),
   .outEnable_n(outEnable_n), .storeStrobe_n(storeStrobe_n), .powerFailIn(powerFailIn),
   .powerFailOut(powerFailOut), .powerFailOe(powerFailOe));

// [tb/nvt_host_model.sv]
// host processor bus model driving the sram-style pins
`timescale 1ns/100ps
module nvt_host_model
   import nvt_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic [7:0]  dataOut,
   input  wire logic        dataOe,
   output logic      [12:0] addrIn,
   output logic      [7:0]  dataIn,
   output logic             chipSelLow_n,
   output logic             chip_select_hi,
   output logic             outEnable_n,
   output logic             storeStrobe_n
);
   // reads that never saw the pins driven
   int stalls = 0;
   initial begin
      addrIn = 13'h0000;
      dataIn = 8'h00;
      {chipSelLow_n, chip_select_hi, outEnable_n, storeStrobe_n} = 4'b1011;
   end
   // =============================================
   // write: address and data held through the strobe, then deselected recovery
   // oeFirst opens a read before the strobe falls, so the device must hand the bus back
   task automatic wr(input logic [12:0] a, input logic [7:0] d, input logic oeFirst = 1'b0);
      @(negedge clk_sys);
      addrIn = a;
      dataIn = d;
      if (oeFirst) begin
         {chipSelLow_n, chip_select_hi, outEnable_n} = 3'b010;
         repeat (8) @(negedge clk_sys);
      end
      {chipSelLow_n, chip_select_hi, storeStrobe_n} = 3'b010;
      repeat (8) @(negedge clk_sys);
      {chipSelLow_n, outEnable_n, storeStrobe_n} = 3'b111;
      repeat (6) @(negedge clk_sys);
      dataIn = ~d; // released bus shows no stale value
   endtask : wr
   // =============================================
   // read: wait for drive, sample, then hold n cycles counting bit 0 toggles
   task automatic rd(input logic [12:0] a, input int n, output logic [7:0] d, output int tg);
      int   k;
      logic p;
      @(negedge clk_sys);
      addrIn = a;
      {chipSelLow_n, chip_select_hi, outEnable_n} = 3'b010;
      k = 0;
      tg = 0;
      while (dataOe !== 1'b1 && k < 30) begin
         @(negedge clk_sys);
         k++;
      end
      if (dataOe !== 1'b1) stalls++;
      repeat (2) @(negedge clk_sys);
      d = dataOut;
      p = dataOut[0];
      repeat (n) begin
         @(negedge clk_sys);
         if (dataOut[0] !== p) tg++;
         p = dataOut[0];
      end
      {chipSelLow_n, outEnable_n} = 2'b11;
      repeat (6) @(negedge clk_sys);
   endtask : rd
endmodule : nvt_host_model

// [tb/nvt_timekeeper_bench.sv]
// self-checking bench for the timekeeping ram
`timescale 1ns/100ps
module nvt_timekeeper_bench;
   import nvt_pkg::*;
   localparam int unsigned SD = 50;
   localparam int unsigned TD = 5;
   logic        clk_sys = 1'b0;
   logic        rst_n = 1'b0;
   logic        powerFailIn = 1'b0;
   logic [12:0] addrIn;
   logic [12:0] ra[7];
   logic [7:0]  dataIn, dataOut, rv, s0, yr;
   logic [7:0]  v[7], t[7], e[7];
   logic        dataOe, chipSelLow_n, chip_select_hi, outEnable_n, storeStrobe_n;
   logic        powerFailOut, powerFailOe;
   int          miscompares = 0, comparisons = 0, seed = 41, tg, n;
   always #5 clk_sys = ~clk_sys;
   nvt_timekeeper #(.SEC_DIV(SD), .TEST_DIV(TD)) nvt_timekeeper_inst (
      .clk_sys(clk_sys), .rst_n(rst_n), .addrIn(addrIn), .dataIn(dataIn), .dataOut(dataOut),
      .dataOe(dataOe), .chipSelLow_n(chipSelLow_n), .chip_select_hi(chip_select_hi),
      .outEnable_n(outEnable_n), .storeStrobe_n(storeStrobe_n), .powerFailIn(powerFailIn),
      .powerFailOut(powerFailOut), .powerFailOe(powerFailOe));
   nvt_host_model host (
      .clk_sys(clk_sys), .dataOut(dataOut), .dataOe(dataOe), .addrIn(addrIn), .dataIn(dataIn),
      .chipSelLow_n(chipSelLow_n), .chip_select_hi(chip_select_hi),
      .outEnable_n(outEnable_n), .storeStrobe_n(storeStrobe_n));
   // =============================================
   function automatic logic [7:0] feb_end(input logic [7:0] y);
      return (((y[7:4] * 10 + y[3:0]) % 4) == 0) ? 8'h29 : 8'h28;
   endfunction : feb_end
   task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] sn);
      comparisons++;
      if (sn !== ex) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", nm, ex, sn);
      end
   endtask : chk
   task automatic conclude;
      // reads that timed out waiting for drive count as one mismatch in all
      if (host.stalls != 0) begin
         miscompares++;
         $display("[ERR] read drive expected 0 stalls seen %0d", host.stalls);
      end
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : conclude
   // =============================================
   initial begin
      #400000;
      miscompares++;
      conclude();
   end
   initial begin
      repeat (16) @(negedge clk_sys);
      rst_n = 1'b1;
      repeat (6) @(negedge clk_sys);
      for (int i = 0; i < 7; i++) begin
         ra[i] = (i == 6) ? 13'h1ff7 : {i[2:0], 10'($random(seed))};
         v[i] = 8'($random(seed));
         host.wr(ra[i], v[i], i[0]);
      end
      for (int i = 0; i < 7; i++) begin
         host.rd(ra[i], 0, rv, tg);
         chk("ram byte", v[i], rv);
      end
      $display("test ram done");
      // one random year, then 00 as the leap corner; start one second before midnight
      for (int j = 0; j < 2; j++) begin
         n = $unsigned($random(seed)) % 100;
         yr = (j == 0) ? {4'(n / 10), 4'(n % 10)} : 8'h00;
         host.wr(ADDR_CLOCK_CONTROL, 8'h80);
         t = '{8'h59, 8'h59, 8'h23, 8'h07, 8'h28, 8'h02, yr};
         for (int i = 0; i < 7; i++) host.wr(ADDR_SECONDS_COUNT + 13'(i), t[i]);
         host.wr(ADDR_CLOCK_CONTROL, 8'h00);
         repeat (75) @(negedge clk_sys);
         host.wr(ADDR_CLOCK_CONTROL, 8'h40);
         e = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h03, yr};
         if (feb_end(yr) == 8'h29) begin
            e[4] = 8'h29;
            e[5] = 8'h02;
         end
         for (int i = 0; i < 7; i++) begin
            host.rd(ADDR_SECONDS_COUNT + 13'(i), 0, rv, tg);
            // divider phase allows one or two ticks in the wait
            if (i == 0 && rv === 8'h01) e[0] = 8'h01;
            chk("time field", e[i], rv);
         end
      end
      $display("test rollover done");
      host.rd(ADDR_CLOCK_CONTROL, 0, rv, tg);
      chk("control byte", 8'h40, rv);
      host.rd(ADDR_SECONDS_COUNT, 0, s0, tg);
      repeat (120) @(negedge clk_sys);
      host.rd(ADDR_SECONDS_COUNT, 0, rv, tg);
      chk("frozen seconds", s0, rv);
      host.wr(ADDR_CLOCK_CONTROL, 8'h00);
      host.rd(ADDR_SECONDS_COUNT, 0, rv, tg);
      chk("refresh moved", 8'h01, {7'h00, rv !== s0});
      $display("test freeze done");
      host.wr(ADDR_SECONDS_COUNT, 8'h80);
      host.rd(ADDR_SECONDS_COUNT, 0, s0, tg);
      repeat (120) @(negedge clk_sys);
      host.rd(ADDR_SECONDS_COUNT, 0, rv, tg);
      chk("halted seconds", s0, rv);
      chk("halt bit", 8'h80, rv & 8'h80);
      host.wr(ADDR_SECONDS_COUNT, 8'h00);
      host.wr(ADDR_WEEKDAY_COUNT, 8'h40);
      host.rd(ADDR_SECONDS_COUNT, 60, rv, tg);
      chk("test toggles", 8'h01, {7'h00, tg >= 10 && tg <= 14});
      host.wr(ADDR_WEEKDAY_COUNT, 8'h00);
      $display("test halt and square done");
      powerFailIn = 1'b1;
      repeat (10) @(negedge clk_sys);
      chk("reset pin low", 8'h01, {7'h00, powerFailOe});
      host.wr(ra[0], ~v[0]);
      powerFailIn = 1'b0;
      repeat (10) @(negedge clk_sys);
      chk("reset pin off", 8'h00, {7'h00, powerFailOe});
      host.rd(ra[0], 0, rv, tg);
      chk("ram kept", v[0], rv);
      $display("test power fail done");
      conclude();
   end
endmodule : nvt_timekeeper_bench
